// ---- hdl/pes_host.sv ----
// Host controller that reads and byte-writes a PROM-style EEPROM over its pins
`timescale 1ns/1ps
module pes_host #(
  parameter bit LARGE = 1'b1,
  parameter int unsigned PULSE_CYC = pes_pkg::PROG_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [pes_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pes_pkg::DATA_W-1:0] wdata_i,
  output logic ready_o,
  output logic [pes_pkg::DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic wdone_o,
  output logic [pes_pkg::ADDR_W-2:0] addr_o,
  output logic first_select_n_o,
  output logic programming_high_level_o,
  output logic secondary_select_o,
  output logic tertiary_select_o,
  input wire logic [pes_pkg::DATA_W-1:0] byte_lines_i,
  output logic [pes_pkg::DATA_W-1:0] byte_lines_o,
  output logic byte_lines_oe_n_o
);
  // Read: address out, setup wait, selects on, access wait, capture
  // Write: address and data out, setup wait, pulse, hold, release
  // Requests that arrive while a sequence runs are dropped without notice
  // One byte per write; the memory clears the byte inside the same pulse
  // Pulse length is PULSE_CYC cycles; the default gives 5 ms at 10 MHz

  // Flip-flops between the byte lines and the captured byte
  localparam int unsigned SYNC_STAGES = 2;
  // Highest address bit, shared with the third select on the small part
  localparam int unsigned ADDR_TOP = pes_pkg::ADDR_W - 1;
  // Byte line enable levels; low while the host drives
  localparam logic OE_DRIVE = 1'b0;
  localparam logic OE_RELEASE = 1'b1;

  // Counter loads; each wait lasts one edge longer than its load
  localparam logic [pes_pkg::CNT_W-1:0] SETUP_LOAD = pes_pkg::CNT_W'(pes_pkg::ADDR_SETUP_CYC);
  localparam logic [pes_pkg::CNT_W-1:0] ACCESS_LOAD = pes_pkg::CNT_W'(pes_pkg::READ_ACCESS_CYC + SYNC_STAGES);
  localparam logic [pes_pkg::CNT_W-1:0] PULSE_LOAD = pes_pkg::CNT_W'(PULSE_CYC - 1);
  localparam logic [pes_pkg::CNT_W-1:0] HOLD_LOAD = pes_pkg::CNT_W'(pes_pkg::ADDR_SETUP_CYC);

  // Standby pin levels: first select high, byte lines released
  localparam pes_pkg::pes_pins_t PINS_RST = '{
    addr: '0,
    first_select_n: 1'b1,
    programming_high_level: 1'b0,
    secondary_select: 1'b0,
    tertiary_select: 1'b0,
    byte_lines_out: '0,
    byte_lines_oe_n: OE_RELEASE
  };

  // Idle controller: no answer pending, synchronisers cleared
  localparam pes_pkg::pes_regs_t REGS_RST = '{
    state: pes_pkg::PES_IDLE,
    cnt: '0,
    pins: PINS_RST,
    rdata: '0,
    rvalid: 1'b0,
    wdone: 1'b0,
    sync1: '0,
    sync2: '0
  };

  // Registered state and its next value
  pes_pkg::pes_regs_t q;
  pes_pkg::pes_regs_t d;
  // Level of the shared pin outside reads
  logic idle_sel;

  // Shared pin: top address bit on the large part, third select on the small one
  always_comb begin
    idle_sel = 1'b0;
    if (LARGE) begin
      idle_sel = 1'b1;
    end
  end

  // Next-state logic for the whole controller
  always_comb begin
    d = q;
    // Answer strobes last one cycle
    d.rvalid = 1'b0;
    d.wdone = 1'b0;

    // Two flip-flops before anything reads the byte lines
    d.sync1 = byte_lines_i;
    d.sync2 = q.sync1;

    // Wait counter runs down to zero and stops
    if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end

    unique case (q.state)
      // Waiting for a request; selects rest in standby
      pes_pkg::PES_IDLE: begin
        if (req_i) begin
          // Address first, selects stay inactive
          d.pins.addr = addr_i;
          if (!LARGE) begin
            d.pins.addr[ADDR_TOP] = 1'b0;
          end
          // Setup wait before any select moves
          d.cnt = SETUP_LOAD;
          if (we_i) begin
            // Write data goes out with the address
            d.pins.byte_lines_out = wdata_i;
            d.pins.byte_lines_oe_n = OE_DRIVE;
            d.pins.secondary_select = 1'b0;
            d.state = pes_pkg::PES_WR_SETUP;
          end else begin
            d.state = pes_pkg::PES_RD_SETUP;
          end
        end
      end

      // Address has settled; bring the selects to read levels
      pes_pkg::PES_RD_SETUP: begin
        if (q.cnt == '0) begin
          d.pins.first_select_n = 1'b0;
          d.pins.secondary_select = 1'b1;
          d.pins.tertiary_select = 1'b1;
          // Access wait includes the sync stages
          d.cnt = ACCESS_LOAD;
          d.state = pes_pkg::PES_RD_ACCESS;
        end
      end

      // Access time plus the two sync stages
      pes_pkg::PES_RD_ACCESS: begin
        if (q.cnt == '0) begin
          d.state = pes_pkg::PES_RD_CAPTURE;
        end
      end

      pes_pkg::PES_RD_CAPTURE: begin
        // Byte has settled through both sync stages
        d.rdata = q.sync2;
        d.rvalid = 1'b1;
        // Back to standby so the memory floats its outputs
        d.pins.first_select_n = 1'b1;
        d.pins.secondary_select = 1'b0;
        d.pins.tertiary_select = idle_sel;
        d.state = pes_pkg::PES_IDLE;
      end

      // Address and data have settled; raise the programming high level, first select stays high
      pes_pkg::PES_WR_SETUP: begin
        if (q.cnt == '0) begin
          d.pins.programming_high_level = 1'b1;
          // Pulse length counted from here
          d.cnt = PULSE_LOAD;
          d.state = pes_pkg::PES_WR_PULSE;
        end
      end

      pes_pkg::PES_WR_PULSE: begin
        // Single pulse both erases and programs the byte
        if (q.cnt == '0) begin
          d.pins.programming_high_level = 1'b0;
          d.cnt = HOLD_LOAD;
          d.state = pes_pkg::PES_WR_HOLD;
        end
      end

      pes_pkg::PES_WR_HOLD: begin
        // Keep address and data a little past the pulse
        if (q.cnt == '0) begin
          d.pins.byte_lines_oe_n = OE_RELEASE;
          // Leave every select in standby for the next access
          d.pins.first_select_n = 1'b1;
          d.pins.secondary_select = 1'b0;
          d.pins.tertiary_select = idle_sel;
          d.wdone = 1'b1;
          d.state = pes_pkg::PES_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  // Handshake toward the user side
  assign ready_o = (q.state == pes_pkg::PES_IDLE);

  // Answers, straight from flip-flops
  assign rdata_o = q.rdata;
  assign rvalid_o = q.rvalid;
  assign wdone_o = q.wdone;

  // Address and selects toward the memory
  assign addr_o = q.pins.addr[ADDR_TOP-1:0];
  assign first_select_n_o = q.pins.first_select_n;
  assign programming_high_level_o = q.pins.programming_high_level;
  assign secondary_select_o = q.pins.secondary_select;
  // Shared position carries the top bit on the large part
  assign tertiary_select_o = LARGE ? q.pins.addr[ADDR_TOP] : q.pins.tertiary_select;

  // Byte lines toward the memory
  assign byte_lines_o = q.pins.byte_lines_out;
  assign byte_lines_oe_n_o = q.pins.byte_lines_oe_n;
endmodule

// ---- hdl/pes_pkg.sv ----
// Package for the PROM-style EEPROM host controller
package pes_pkg;
  // Organisation
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W_SMALL = 11;
  localparam int unsigned ADDR_W_LARGE = 12;
  localparam int unsigned ADDR_W = ADDR_W_LARGE;
  // Clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PROG_PULSE_MS = 5;
  localparam int unsigned PROG_PULSE_CYC = (PROG_PULSE_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned ADDR_SETUP_NS = 100;
  localparam int unsigned ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_ACCESS_NS = 200;
  localparam int unsigned READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 16;

  // Operation state
  typedef enum logic [2:0] {
    PES_IDLE,
    PES_RD_SETUP,
    PES_RD_ACCESS,
    PES_RD_CAPTURE,
    PES_WR_SETUP,
    PES_WR_PULSE,
    PES_WR_HOLD
  } pes_state_t;

  // Pins toward the memory
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic first_select_n;
    logic programming_high_level;
    logic secondary_select;
    logic tertiary_select;
    logic [DATA_W-1:0] byte_lines_out;
    logic byte_lines_oe_n;
  } pes_pins_t;

  // Whole controller state
  typedef struct packed {
    pes_state_t state;
    logic [CNT_W-1:0] cnt;
    pes_pins_t pins;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic wdone;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
  } pes_regs_t;
endpackage

// ---- sim/pes_host_checker.sv ----
// Pin-level assertions for the EEPROM host controller
`timescale 1ns/1ps
module pes_host_checker #(parameter int unsigned PULSE_CYC = pes_pkg::PROG_PULSE_CYC) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ready_o,
  input wire logic [10:0] addr_o,
  input wire logic first_select_n_o,
  input wire logic programming_high_level_o,
  input wire logic secondary_select_o,
  input wire logic byte_lines_oe_n_o
);
  logic [15:0] hi_q;
  wire logic pv = programming_high_level_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Length of the running programming pulse
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      hi_q <= 16'h0000;
    else
      hi_q <= pv ? hi_q + 16'h0001 : 16'h0000;
  end
  property p_adr; $fell(first_select_n_o) |-> $stable(addr_o); endproperty
  a_adr: assert property (p_adr) else $error("address moved at select");
  property p_rd; $fell(first_select_n_o) |-> secondary_select_o && byte_lines_oe_n_o; endproperty
  a_rd: assert property (p_rd) else $error("bad read selects");
  property p_hold; $rose(pv) |-> (!byte_lines_oe_n_o && $stable(addr_o))[*8]; endproperty
  a_hold: assert property (p_hold) else $error("write pins moved");
  property p_sel2; pv |-> !secondary_select_o && first_select_n_o; endproperty
  a_sel2: assert property (p_sel2) else $error("select high in write");
  property p_len; $fell(pv) |-> hi_q == PULSE_CYC; endproperty
  a_len: assert property (p_len) else $error("pulse length wrong");
  property p_busy; pv |-> !ready_o; endproperty
  a_busy: assert property (p_busy) else $error("ready in pulse");
  c_rd: cover property ($fell(first_select_n_o));
  c_wr: cover property ($fell(pv));
  c_b2b: cover property ($fell(pv) ##[1:8] $fell(first_select_n_o));
endmodule
bind pes_host pes_host_checker #(.PULSE_CYC(PULSE_CYC)) i_chk (.clk_i, .arst_n_i, .ready_o, .addr_o,
  .first_select_n_o, .programming_high_level_o, .secondary_select_o, .byte_lines_oe_n_o);

// ---- sim/pes_host_tb_top.sv ----
// Self-checking bench for the EEPROM host controller
`timescale 1ns/1ps
module pes_host_tb_top;
  localparam int unsigned PC = 20;
  // Edges from take to answer: setup, access with two sync stages, capture
  localparam int RD_LAT = pes_pkg::ADDR_SETUP_CYC + 1 + pes_pkg::READ_ACCESS_CYC + 3 + 1;
  // Edges from take to answer: setup, pulse, hold
  localparam int WR_LAT = 2 * (pes_pkg::ADDR_SETUP_CYC + 1) + PC;
  logic clk_i = 1'b0, arst_n_i = 1'b0, req_i = 1'b0, we_i = 1'b0, ready_o, rvalid_o, wdone_o, fs_n, hv, s2, s3, oe_n;
  logic [11:0] addr_i = 12'h000;
  logic [10:0] addr_o;
  logic [7:0] wdata_i = 8'h00, rdata_o, byte_lines_i, byte_lines_o, mq, q;
  logic ready_s, rvalid_s, wdone_s, fs_n_s, hv_s, s2_s, s3_s, oe_n_s;
  logic [10:0] addr_s;
  logic [7:0] rdata_s, bl_in_s, bl_out_s, mq_s, q_s;
  int failures = 0, tests_run = 0;
  pes_host #(.PULSE_CYC(PC)) i_dut (.clk_i, .arst_n_i, .req_i, .we_i, .addr_i, .wdata_i, .ready_o, .rdata_o,
    .rvalid_o, .wdone_o, .addr_o, .first_select_n_o(fs_n), .programming_high_level_o(hv), .secondary_select_o(s2),
    .tertiary_select_o(s3), .byte_lines_i, .byte_lines_o, .byte_lines_oe_n_o(oe_n));
  pes_mem_model i_mem (.a_i({s3, addr_o}), .sel_n_i(fs_n), .hv_i(hv), .sel2_i(s2), .d_i(byte_lines_o), .q_o(mq));
  // Shared byte lines: host wins while its enable is low
  assign byte_lines_i = oe_n ? mq : byte_lines_o;
  // Small part beside it, fed the same requests
  pes_host #(.LARGE(1'b0), .PULSE_CYC(PC)) i_dut_s (.clk_i, .arst_n_i, .req_i, .we_i, .addr_i, .wdata_i,
    .ready_o(ready_s), .rdata_o(rdata_s), .rvalid_o(rvalid_s), .wdone_o(wdone_s), .addr_o(addr_s),
    .first_select_n_o(fs_n_s), .programming_high_level_o(hv_s), .secondary_select_o(s2_s),
    .tertiary_select_o(s3_s), .byte_lines_i(bl_in_s), .byte_lines_o(bl_out_s), .byte_lines_oe_n_o(oe_n_s));
  pes_mem_model #(.LARGE(1'b0)) i_mem_s (.a_i({s3_s, addr_s}), .sel_n_i(fs_n_s), .hv_i(hv_s), .sel2_i(s2_s),
    .d_i(bl_out_s), .q_o(mq_s));
  assign bl_in_s = oe_n_s ? mq_s : bl_out_s;
  initial forever #50 clk_i = ~clk_i;
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // One request held for one cycle without looking at ready_o, then a bounded wait for its answer
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, input int lat);
    int n = 0;
    @(posedge clk_i);
    req_i <= 1'b1;
    we_i <= w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    req_i <= 1'b0;
    do begin
      @(negedge clk_i);
      n++;
    end while ((w ? wdone_o : rvalid_o) !== 1'b1 && n < 200);
    q = rdata_o;
    q_s = rdata_s;
    // The answer is seen at the falling edge after the edge that raised it
    chk(n == lat + 1, "answer latency");
    chk((w ? wdone_s : rvalid_s) === 1'b1, "small part out of step");
  endtask
  task automatic t_read();
    xfer(1'b0, 12'hABC, 8'h00, RD_LAT);
    chk(q === (8'hBC ^ 8'hAB), "read top half");
    chk(q_s === (8'hBC ^ 8'h2B), "small read drops top bit");
    xfer(1'b0, 12'h2BC, 8'h00, RD_LAT);
    chk(q === (8'hBC ^ 8'h2B), "read low half");
    chk(q_s === (8'hBC ^ 8'h2B), "small read low half");
    $display("test read done");
  endtask
  task automatic t_write();
    xfer(1'b1, 12'h801, 8'hA5, WR_LAT);
    xfer(1'b0, 12'h801, 8'h00, RD_LAT);
    chk(q === 8'hA5, "written byte");
    chk(q_s === 8'hA5, "small written byte");
    xfer(1'b1, 12'h801, 8'h5A, WR_LAT);
    xfer(1'b0, 12'h001, 8'h00, RD_LAT);
    chk(q === 8'h01, "twin untouched");
    chk(q_s === 8'h5A, "small rewritten byte");
    xfer(1'b0, 12'h801, 8'h00, RD_LAT);
    chk(q === 8'h5A, "rewritten byte");
    chk(q_s === 8'h5A, "small top half folds");
    $display("test write done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Run needs about 105 cycles; allow 2000, about nineteen times that
  initial begin
    #200_000;
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    chk(fs_n === 1'b1 && hv === 1'b0 && oe_n === 1'b1 && ready_o === 1'b1, "idle pins");
    chk(fs_n_s === 1'b1 && hv_s === 1'b0 && oe_n_s === 1'b1 && ready_s === 1'b1, "small idle pins");
    $display("test idle done");
    arst_n_i <= 1'b1;
    t_read();
    t_write();
    tally_and_finish();
  end
endmodule

// ---- sim/pes_mem_model.sv ----
// Behavioural model of the PROM-style byte memory
`timescale 1ns/1ps
module pes_mem_model #(parameter bit LARGE = 1'b1) (
  input wire logic [11:0] a_i,
  input wire logic sel_n_i,
  input wire logic hv_i,
  input wire logic sel2_i,
  input wire logic [7:0] d_i,
  output logic [7:0] q_o
);
  logic [7:0] mem [4096];
  logic [11:0] a_eff;
  logic sel;
  // Small part: the shared position is the third select, not an address bit
  assign a_eff = LARGE ? a_i : {1'b0, a_i[10:0]};
  assign sel = !sel_n_i && sel2_i && (LARGE || a_i[11]);
  // Drives the byte only when fully selected, else the inverted byte
  assign q_o = sel ? mem[a_eff] : ~mem[a_eff];
  initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ i[11:4];
  // Pulse start clears the byte, pulse end programs it
  always @(posedge hv_i) if (!sel2_i) mem[a_eff] = 8'hFF;
  always @(negedge hv_i) if (!sel2_i) mem[a_eff] = d_i;
endmodule
